// ===== logic/timer_cfg.svh
// Register offsets, field positions, reset values and rates for the timer pair
// Assumes a byte-wide register port and a 25 MHz system clock
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

// Register offsets
`define OFS_T1_RELOAD_HI 8'h15
`define OFS_T1_RELOAD_LO 8'h16
`define OFS_T1_COUNT_HI 8'h17
`define OFS_T1_COUNT_LO 8'h18
`define OFS_T2_CONTROL 8'h19
`define OFS_T2_RELOAD_HI 8'h1a
`define OFS_T2_RELOAD_LO 8'h1b
`define OFS_T2_COUNT_HI 8'h1c
`define OFS_T2_COUNT_LO 8'h1d
`define OFS_T1_CONTROL 8'h30
`define OFS_IRQ_STATUS 8'h31
`define OFS_IRQ_MASK 8'h32
`define OFS_COMMAND 8'h33

// Control register fields
`define CTL_STOP_RX_BIT 7
`define CTL_START_HI 5
`define CTL_START_LO 4
`define CTL_RESTART_BIT 3
`define CTL_CLK_HI 1
`define CTL_CLK_LO 0
`define CTL_WRITE_MASK 8'hbb

// Interrupt and command bits
`define IRQ_T1_BIT 0
`define IRQ_T2_BIT 1
`define IRQ_WRITE_MASK 8'h03
`define CMD_T1_START_BIT 0
`define CMD_T2_START_BIT 1
`define CMD_T1_STOP_BIT 2
`define CMD_T2_STOP_BIT 3

// Reset values
`define RELOAD_RESET 8'h00
`define CONTROL_RESET 8'h00
`define IRQ_RESET 8'h00

// Rates in kHz
`define CLK_KHZ 25000
`define FAST_KHZ 13560
`define SLOW_KHZ 212

`endif

// ===== logic/timer_pkg.sv
// Types shared by the timer pair
// Assumes the cfg header carries every number
package timer_pkg;
    typedef enum logic [1:0] {
        START_NONE,
        START_TX_END,
        START_TRIM_QUIET,
        START_TRIM_FLOW
    } start_mode_t;

    typedef enum logic [1:0] {
        SRC_FAST,
        SRC_SLOW,
        SRC_TIMER0,
        SRC_OTHER
    } clock_select_t;

    typedef logic [7:0] byte_t;
    typedef logic [15:0] count_t;
endpackage

// ===== logic/rate_divider.sv
// Fractional divider: one-cycle enable pulses at an average rate from the clock
// Assumes rates given in kHz and below the clock rate
`timescale 1ns/10ps
`include "timer_cfg.svh"
module rate_divider #(
    parameter int RATE_KHZ = 212
) (
    input wire logic clk,
    input wire logic rst_n,
    output logic tick
);
    localparam int INC = (RATE_KHZ * 65536) / `CLK_KHZ;

    logic [15:0] acc_q;
    logic [16:0] sum;

    assign sum = {1'b0, acc_q} + {1'b0, INC[15:0]};

    // Carry out of the accumulator marks one period of the slower rate
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc_q <= 16'h0000;
            tick <= 1'b0;
        end else begin
            acc_q <= sum[15:0];
            tick <= sum[16];
        end
    end
endmodule // rate_divider

// ===== logic/down_timer.sv
// One 16-bit down-counter with reload, auto-restart and underflow pulse
// Assumes start and stop are one-cycle pulses and tick a one-cycle enable
`timescale 1ns/10ps
module down_timer
    import timer_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic start,
    input wire logic stop,
    input wire logic auto_restart,
    input wire logic allow_underflow,
    input wire count_t reload,
    output count_t count,
    output logic running,
    output logic underflow
);
    // Start wins over stop and tick; a stop halts at once
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count <= 16'h0000;
            running <= 1'b0;
            underflow <= 1'b0;
        end else begin
            underflow <= 1'b0;
            if (start) begin
                count <= reload;
                running <= 1'b1;
            end else if (stop) begin
                running <= 1'b0;
            end else if (running && tick) begin
                if (count != 16'h0000) begin
                    count <= count - 16'h0001;
                end else if (!allow_underflow) begin
                    count <= count;
                end else begin
                    underflow <= 1'b1;
                    if (auto_restart) begin
                        count <= reload;
                    end else begin
                        running <= 1'b0;
                    end
                end
            end
        end
    end
endmodule // down_timer

// ===== logic/reader_timer_one_two.sv
// Timer one and timer two of the reader timer unit, with register port and interrupt
// Assumes synchronous event inputs and a 25 MHz clock
//
// Operation
// - Timer one loads reload word at start
// - Reload writes wait for next start or auto-restart reload
// - Count high byte of timer one readable
// - Count low byte of timer one readable
// - Stop-on-receive halts after first four bits
// - Stop-on-receive ignored in trimming modes
// - Start mode: none or end of transmission
// - Trimming modes start/stop on oscillator rise
// - Auto-restart reloads at zero
// - Without auto-restart, stop at zero
// - Timer two underflow sets its flag
// - Timer two clock source selection
// - Timer two reload copied at start
// - Timer one may count timer two underflows
`timescale 1ns/10ps
`include "timer_cfg.svh"
module reader_timer_one_two
    import timer_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output byte_t rdata,
    input wire logic tx_end,
    input wire logic rx_first_bits,
    input wire logic slow_oscillator,
    input wire logic timer0_underflow,
    output logic first_timer_underflow,
    output logic second_timer_underflow,
    output logic irq
);
    byte_t first_timer_reload_upper_q;
    byte_t first_timer_reload_lower_q;
    byte_t first_timer_control_q;
    byte_t second_timer_control_q;
    byte_t second_timer_reload_upper_q;
    byte_t second_timer_reload_lower_q;
    byte_t irq_status_q;
    byte_t irq_mask_q;
    byte_t rdata_d;
    logic osc_prev_q;
    logic osc_rise;
    logic fast_tick;
    logic slow_tick;
    logic first_tick;
    logic second_tick;
    logic [1:0] first_events;
    logic [1:0] second_events;
    logic first_start;
    logic first_stop;
    logic second_start;
    logic second_stop;
    logic first_running;
    logic second_running;
    count_t first_count;
    count_t second_count;
    logic cmd_write;
    logic status_write;

    // Start and stop decision for one timer from its control byte
    function automatic logic [1:0] start_stop(
        input byte_t ctl,
        input logic tx_done,
        input logic rx4,
        input logic osc_up,
        input logic active
    );
        start_mode_t mode;
        logic trim;
        logic go;
        logic halt;
        mode = start_mode_t'(ctl[`CTL_START_HI:`CTL_START_LO]);
        trim = (mode == START_TRIM_QUIET) || (mode == START_TRIM_FLOW);
        go = (mode == START_TX_END) && tx_done;
        go = go || (trim && osc_up && !active);
        halt = trim && osc_up && active;
        halt = halt || (!trim && ctl[`CTL_STOP_RX_BIT] && rx4);
        start_stop = {halt, go};
    endfunction

    // Counting source for one timer
    function automatic logic tick_select(
        input byte_t ctl,
        input logic fast,
        input logic slow,
        input logic zero_flow,
        input logic other_flow
    );
        clock_select_t sel;
        sel = clock_select_t'(ctl[`CTL_CLK_HI:`CTL_CLK_LO]);
        case (sel)
            SRC_FAST: tick_select = fast;
            SRC_SLOW: tick_select = slow;
            SRC_TIMER0: tick_select = zero_flow;
            SRC_OTHER: tick_select = other_flow;
            default: tick_select = 1'b0;
        endcase
    endfunction

    // Underflow is suppressed only in the quiet trimming mode
    function automatic logic flow_allowed(input byte_t ctl);
        flow_allowed = start_mode_t'(ctl[`CTL_START_HI:`CTL_START_LO]) != START_TRIM_QUIET;
    endfunction

    // Source rate enables
    rate_divider #(
        .RATE_KHZ(`FAST_KHZ)
    ) fast_div (
        .clk(clk),
        .rst_n(rst_n),
        .tick(fast_tick)
    );

    rate_divider #(
        .RATE_KHZ(`SLOW_KHZ)
    ) slow_div (
        .clk(clk),
        .rst_n(rst_n),
        .tick(slow_tick)
    );

    // Slow oscillator rising edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            osc_prev_q <= 1'b0;
        end else begin
            osc_prev_q <= slow_oscillator;
        end
    end

    assign osc_rise = slow_oscillator && !osc_prev_q;

    // Tick selection, cascading in both directions
    assign first_tick = tick_select(first_timer_control_q, fast_tick, slow_tick, timer0_underflow,
                                    second_timer_underflow);
    assign second_tick = tick_select(second_timer_control_q, fast_tick, slow_tick, timer0_underflow,
                                     first_timer_underflow);

    // Start and stop events, automatic and by command
    assign cmd_write = wr && (addr == `OFS_COMMAND);
    assign first_events = start_stop(first_timer_control_q, tx_end, rx_first_bits, osc_rise, first_running);
    assign second_events = start_stop(second_timer_control_q, tx_end, rx_first_bits, osc_rise, second_running);
    assign first_start = first_events[0] || (cmd_write && wdata[`CMD_T1_START_BIT]);
    assign second_start = second_events[0] || (cmd_write && wdata[`CMD_T2_START_BIT]);
    assign first_stop = first_events[1] || (cmd_write && wdata[`CMD_T1_STOP_BIT]);
    assign second_stop = second_events[1] || (cmd_write && wdata[`CMD_T2_STOP_BIT]);

    // Timer one counts from the reload word captured at start
    down_timer first_timer (
        .clk(clk),
        .rst_n(rst_n),
        .tick(first_tick),
        .start(first_start),
        .stop(first_stop),
        .auto_restart(first_timer_control_q[`CTL_RESTART_BIT]),
        .allow_underflow(flow_allowed(first_timer_control_q)),
        .reload({first_timer_reload_upper_q, first_timer_reload_lower_q}),
        .count(first_count),
        .running(first_running),
        .underflow(first_timer_underflow)
    );

    // Timer two
    down_timer second_timer (
        .clk(clk),
        .rst_n(rst_n),
        .tick(second_tick),
        .start(second_start),
        .stop(second_stop),
        .auto_restart(second_timer_control_q[`CTL_RESTART_BIT]),
        .allow_underflow(flow_allowed(second_timer_control_q)),
        .reload({second_timer_reload_upper_q, second_timer_reload_lower_q}),
        .count(second_count),
        .running(second_running),
        .underflow(second_timer_underflow)
    );

    // Reload bytes feed the counter at a start event or an auto-restart reload
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            first_timer_reload_upper_q <= `RELOAD_RESET;
            first_timer_reload_lower_q <= `RELOAD_RESET;
        end else if (wr) begin
            if (addr == `OFS_T1_RELOAD_HI) begin
                first_timer_reload_upper_q <= wdata;
            end
            if (addr == `OFS_T1_RELOAD_LO) begin
                first_timer_reload_lower_q <= wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            second_timer_reload_upper_q <= `RELOAD_RESET;
            second_timer_reload_lower_q <= `RELOAD_RESET;
        end else if (wr) begin
            if (addr == `OFS_T2_RELOAD_HI) begin
                second_timer_reload_upper_q <= wdata;
            end
            if (addr == `OFS_T2_RELOAD_LO) begin
                second_timer_reload_lower_q <= wdata;
            end
        end
    end

    // Control bytes; reserved bits never stored
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            first_timer_control_q <= `CONTROL_RESET;
            second_timer_control_q <= `CONTROL_RESET;
        end else if (wr) begin
            if (addr == `OFS_T1_CONTROL) begin
                first_timer_control_q <= wdata & `CTL_WRITE_MASK;
            end
            if (addr == `OFS_T2_CONTROL) begin
                second_timer_control_q <= wdata & `CTL_WRITE_MASK;
            end
        end
    end

    // Sticky underflow flags, write one to clear, set wins
    assign status_write = wr && (addr == `OFS_IRQ_STATUS);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_status_q <= `IRQ_RESET;
        end else begin
            if (status_write) begin
                irq_status_q <= irq_status_q & ~(wdata & `IRQ_WRITE_MASK);
            end
            if (first_timer_underflow) begin
                irq_status_q[`IRQ_T1_BIT] <= 1'b1;
            end
            if (second_timer_underflow) begin
                irq_status_q[`IRQ_T2_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_mask_q <= `IRQ_RESET;
        end else if (wr && (addr == `OFS_IRQ_MASK)) begin
            irq_mask_q <= wdata & `IRQ_WRITE_MASK;
        end
    end

    assign irq = |(irq_status_q & irq_mask_q);

    // Read decode; counts are live, unmapped offsets read zero
    always_comb begin
        case (addr)
            `OFS_T1_RELOAD_HI: rdata_d = first_timer_reload_upper_q;
            `OFS_T1_RELOAD_LO: rdata_d = first_timer_reload_lower_q;
            `OFS_T1_COUNT_HI: rdata_d = first_count[15:8];
            `OFS_T1_COUNT_LO: rdata_d = first_count[7:0];
            `OFS_T2_CONTROL: rdata_d = second_timer_control_q & `CTL_WRITE_MASK;
            `OFS_T2_RELOAD_HI: rdata_d = second_timer_reload_upper_q;
            `OFS_T2_RELOAD_LO: rdata_d = second_timer_reload_lower_q;
            `OFS_T2_COUNT_HI: rdata_d = second_count[15:8];
            `OFS_T2_COUNT_LO: rdata_d = second_count[7:0];
            `OFS_T1_CONTROL: rdata_d = first_timer_control_q;
            `OFS_IRQ_STATUS: rdata_d = irq_status_q;
            `OFS_IRQ_MASK: rdata_d = irq_mask_q;
            default: rdata_d = 8'h00;
        endcase
    end

    // Read data stands in the cycle after the strobe only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (rd) begin
            rdata <= rdata_d;
        end else begin
            rdata <= 8'h00;
        end
    end
endmodule // reader_timer_one_two

// ===== verification/timer_pair_props.sv
// Checker for the timer pair register port, underflow pulse and interrupt
// Assumes it is bound to reader_timer_one_two and sees only its ports
`timescale 1ns/10ps
module timer_pair_props
    import timer_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire byte_t rdata,
    input wire logic tx_end,
    input wire logic rx_first_bits,
    input wire logic timer0_underflow,
    input wire logic second_timer_underflow,
    input wire logic irq
);
    byte_t ctl_q;
    byte_t rel_q;

    // Shadow copies of the timer two control and upper reload bytes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctl_q <= 8'h00;
            rel_q <= 8'h00;
        end else if (wr && addr == 8'h19) begin
            ctl_q <= wdata & 8'hbb;
        end else if (wr && addr == 8'h1a) begin
            rel_q <= wdata;
        end
    end

    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_read_idle: assert property (!rd |=> rdata == 8'h00)
        else $error("rdata not zero outside a read");
    a_unmapped_zero: assert property (rd && !(addr inside {[8'h15:8'h1d], [8'h30:8'h32]})
        |=> rdata == 8'h00) else $error("unmapped read not zero");
    a_reset_quiet: assert property (disable iff (1'b0)
        !rst_n |=> rdata == 8'h00 && !irq && !second_timer_underflow) else $error("outputs active after reset");
    a_ctl_readback: assert property (rd && addr == 8'h19 |=> rdata == ctl_q)
        else $error("control readback wrong");
    a_reload_readback: assert property (rd && addr == 8'h1a |=> rdata == rel_q)
        else $error("reload readback wrong");
    a_quiet_trim: assert property (ctl_q[5:4] == 2'h2 && $past(ctl_q[5:4]) == 2'h2
        |-> !second_timer_underflow) else $error("underflow in quiet trim mode");
    a_timer0_source: assert property ($past(ctl_q[1:0]) == 2'h2 && second_timer_underflow
        |-> $past(timer0_underflow)) else $error("underflow without a timer0 tick");
    a_stop_on_rx: assert property (ctl_q[7] && !ctl_q[5] && rx_first_bits && !tx_end
        && !(wr && addr == 8'h33) |=> !second_timer_underflow [*2]) else $error("timer ran on after rx");
    a_mask_clears_irq: assert property (wr && addr == 8'h32 && wdata == 8'h00 |=> !irq)
        else $error("irq high with mask clear");

    c_underflow: cover property (second_timer_underflow);
    c_rx_stop: cover property (ctl_q[7] && rx_first_bits);
    c_irq: cover property (irq);
endmodule // timer_pair_props

bind reader_timer_one_two timer_pair_props i_timer_pair_props (.clk, .rst_n, .addr, .wdata, .wr, .rd,
    .rdata, .tx_end, .rx_first_bits, .timer0_underflow, .second_timer_underflow, .irq);

// ===== verification/tb_reader_timer_one_two.sv
// Self-checking bench for the timer pair
// Assumes the bench drives all ports; timers counted by timer0 pulses except in the cascade and rate tests
`timescale 1ns/10ps
module tb_reader_timer_one_two
    import timer_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic osc = 1'b0;
    logic [2:0] ev = 3'h0;
    byte_t rdata;
    byte_t v;
    logic uf2;
    logic uf1;
    int n1 = 0;
    logic irq;
    int error_cnt = 0;
    int checked = 0;
    int cyc = 0;
    int n2 = 0;
    logic [23:0] rows [8] = '{24'h15_a5a5, 24'h16_5a5a, 24'h19_ffbb, 24'h1a_3c3c,
                              24'h17_ff00, 24'h18_ff00, 24'h33_0000, 24'h40_ff00};

    reader_timer_one_two i_reader_timer_one_two (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
        .tx_end(ev[1]), .rx_first_bits(ev[2]), .slow_oscillator(osc), .timer0_underflow(ev[0]),
        .first_timer_underflow(uf1), .second_timer_underflow(uf2), .irq);

    always #20 clk = ~clk;

    task automatic wrap_up();
        $display("Checks %0d, errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Cycle count, underflow tally and hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (uf2 === 1'b1) begin
            n2 <= n2 + 1;
        end
        if (uf1 === 1'b1) begin
            n1 <= n1 + 1;
        end
        if (cyc == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic w(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        v = rdata;
    endtask

    task automatic r(input logic [7:0] a, input logic [7:0] e);
        rg(a);
        chk(v, e);
    endtask

    // Pulse event k (0 timer0, 1 tx end, 2 rx bits) n times
    task automatic p(input int k, input int n);
        repeat (n) begin
            @(posedge clk);
            ev <= 3'h1 << k;
            @(posedge clk);
            ev <= 3'h0;
        end
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 8'h15; a <= 8'h1d; a++) r(8'(a), 8'h00);
        for (int i = 0; i < 8; i++) begin
            w(rows[i][23:16], rows[i][15:8]);
            r(rows[i][23:16], rows[i][7:0]);
        end
        // Timer one load, live bytes, late reload
        w(8'h30, 8'h02);
        w(8'h15, 8'h01);
        w(8'h16, 8'h03);
        w(8'h33, 8'h01);
        w(8'h16, 8'h05);
        w(8'h15, 8'h00);
        r(8'h17, 8'h01);
        r(8'h18, 8'h03);
        p(0, 3);
        w(8'h18, 8'hff);
        r(8'h18, 8'h00);
        r(8'h17, 8'h01);
        w(8'h33, 8'h01);
        r(8'h18, 8'h05);
        w(8'h33, 8'h04);
        // Timer two one-shot, flag and irq
        w(8'h32, 8'h02);
        w(8'h19, 8'h02);
        w(8'h1a, 8'h00);
        w(8'h1b, 8'h02);
        w(8'h33, 8'h02);
        w(8'h1a, 8'h01);
        p(0, 2);
        r(8'h1c, 8'h00);
        chk(16'(n2), 16'h0000);
        p(0, 1);
        r(8'h31, 8'h02);
        chk(irq, 1'b1);
        chk(16'(n2), 16'h0001);
        p(0, 2);
        r(8'h1d, 8'h00);
        chk(16'(n2), 16'h0001);
        // Auto-restart with the interrupt masked
        w(8'h31, 8'h03);
        w(8'h32, 8'h00);
        w(8'h1a, 8'h00);
        w(8'h19, 8'h0a);
        w(8'h33, 8'h02);
        p(0, 6);
        r(8'h1d, 8'h02);
        chk(16'(n2), 16'h0003);
        chk(irq, 1'b0);
        w(8'h32, 8'h02);
        r(8'h31, 8'h02);
        chk(irq, 1'b1);
        w(8'h33, 8'h08);
        w(8'h31, 8'h02);
        r(8'h31, 8'h00);
        chk(irq, 1'b0);
        // Start on transmit end, stop on receive
        w(8'h1b, 8'h05);
        w(8'h19, 8'h92);
        p(1, 1);
        p(0, 1);
        p(2, 1);
        p(0, 2);
        r(8'h1d, 8'h04);
        w(8'h19, 8'h82);
        p(1, 1);
        r(8'h1d, 8'h04);
        w(8'h19, 8'h12);
        p(1, 1);
        p(2, 1);
        p(0, 2);
        r(8'h1d, 8'h03);
        // Trimming modes
        w(8'h33, 8'h08);
        w(8'h1b, 8'h01);
        w(8'h19, 8'ha2);
        @(posedge clk) osc <= 1'b1;
        p(2, 1);
        p(0, 3);
        r(8'h1d, 8'h00);
        chk(16'(n2), 16'h0003);
        w(8'h33, 8'h08);
        w(8'h19, 8'h32);
        @(posedge clk) osc <= 1'b0;
        @(posedge clk) osc <= 1'b1;
        p(0, 2);
        r(8'h1d, 8'h00);
        chk(16'(n2), 16'h0004);
        // Cascade in both directions
        w(8'h33, 8'h08);
        w(8'h19, 8'h03);
        w(8'h1b, 8'h05);
        w(8'h30, 8'h0a);
        w(8'h16, 8'h00);
        w(8'h33, 8'h03);
        p(0, 3);
        r(8'h1d, 8'h02);
        chk(16'(n1), 16'h0003);
        w(8'h30, 8'h0b);
        w(8'h19, 8'h0a);
        w(8'h1b, 8'h00);
        w(8'h16, 8'h05);
        w(8'h33, 8'h03);
        p(0, 2);
        r(8'h18, 8'h03);
        // Fast and slow tick rates
        w(8'h33, 8'h0c);
        w(8'h1b, 8'h64);
        w(8'h19, 8'h00);
        w(8'h33, 8'h02);
        repeat (100) @(posedge clk);
        rg(8'h1d);
        chk(v inside {[8'h26:8'h34]}, 1'b1);
        w(8'h19, 8'h01);
        w(8'h33, 8'h02);
        repeat (500) @(posedge clk);
        rg(8'h1d);
        chk(v inside {[8'h5e:8'h61]}, 1'b1);
        // Reset in mid-run clears registers and the interrupt
        w(8'h15, 8'h77);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        r(8'h15, 8'h00);
        r(8'h19, 8'h00);
        r(8'h1d, 8'h00);
        chk(irq, 1'b0);
        wrap_up();
    end
endmodule // tb_reader_timer_one_two
